/* core/event_log_viewer_ui_cfg.svh */
// Purpose: constants for the event log viewer front end
// Assumes: 40 MHz core clock
// Notes:   timestamp packs day, month, year, hour and minute fields
`ifndef EVENT_LOG_VIEWER_UI_CFG_SVH
`define EVENT_LOG_VIEWER_UI_CFG_SVH

`define CLK_HZ          64'd40000000
`define BL_TIMEOUT_S    64'd30
`define PROG_TIMEOUT_M  64'd5
`define PROG_HOLD_S     64'd2
`define BLINK_HALF_MS   64'd500
`define BL_CYCLES       (`BL_TIMEOUT_S * `CLK_HZ)
`define PROG_CYCLES     (`PROG_TIMEOUT_M * 64'd60 * `CLK_HZ)
`define HOLD_CYCLES     (`PROG_HOLD_S * `CLK_HZ)
`define BLINK_CYCLES    (`BLINK_HALF_MS * `CLK_HZ / 64'd1000)
`define TMR_W           40

`define DISP_ROWS       2
`define DISP_COLS       16

`define LOG_DEPTH       256
`define LOG_AW          8
`define CODE_W          8
`define NUM_LANG        4
`define LANG_W          2

`define TS_W            27
`define FLD_W           7
`define NUM_FLD         5
`define TS_MIN_LSB      0
`define TS_MIN_W        6
`define TS_HOUR_LSB     6
`define TS_HOUR_W       5
`define TS_YEAR_LSB     11
`define TS_YEAR_W       7
`define TS_MON_LSB      18
`define TS_MON_W        4
`define TS_DAY_LSB      22
`define TS_DAY_W        5

`define FLD_DAY         3'h0
`define FLD_MON         3'h1
`define FLD_YEAR        3'h2
`define FLD_HOUR        3'h3
`define FLD_MIN         3'h4

`define LANG_RST        2'h0

`endif

/* core/event_log_viewer_ui_pkg.sv */
// Purpose: types for the event log viewer front end
// Assumes: none
// Notes:   event codes are a fixed message set shared with the panel
package event_log_viewer_ui_pkg;

  typedef enum logic [6:0] {
    ST_NORMAL  = 7'h01,
    ST_MENU    = 7'h02,
    ST_BROWSE  = 7'h04,
    ST_PROG    = 7'h08,
    ST_PMENU   = 7'h10,
    ST_SETCLK  = 7'h20,
    ST_SETLANG = 7'h40
  } ui_state_t;

  typedef enum logic [0:0] {
    PITEM_DATE = 1'h0,
    PITEM_LANG = 1'h1
  } prog_item_t;

  typedef enum logic [7:0] {
    EVT_POWER_ON    = 8'h01,
    EVT_MAINS_LOSS  = 8'h02,
    EVT_MAINS_OK    = 8'h03,
    EVT_PANEL_RESET = 8'h04,
    EVT_SND_FAULT   = 8'h05,
    EVT_SND_FLT_RST = 8'h06,
    EVT_ZONE_FIRE   = 8'h07,
    EVT_ZONE_TEST   = 8'h08,
    EVT_ZONE_FAULT  = 8'h09,
    EVT_ZONE_OK     = 8'h0A,
    EVT_SYS_FAULT   = 8'h0B
  } evt_code_t;

endpackage

/* core/idle_timer.sv */
// Purpose: cycle timeout that restarts on demand and holds its expiry
// Assumes: restart has priority over counting
// Notes:   expired stays high until the next restart
`timescale 1ns/10ps
`include "event_log_viewer_ui_cfg.svh"
module idle_timer #(
  parameter logic [`TMR_W-1:0] CYCLES = `TMR_W'(`BL_CYCLES)
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic restart_i,
  input  wire logic run_i,
  output logic      expired_o
);
  logic [`TMR_W-1:0] cnt_reg;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg   <= '0;
      expired_o <= 1'b0;
    end
    else if (restart_i)
    begin
      cnt_reg   <= '0;
      expired_o <= 1'b0;
    end
    else if (run_i && !expired_o)
    begin
      cnt_reg   <= cnt_reg + `TMR_W'(1);
      expired_o <= (cnt_reg == CYCLES - `TMR_W'(1));
    end
  end
endmodule

/* core/event_log_viewer_ui.sv */
// Purpose: event logging and menu front end for the log add-on
// Assumes: buttons and link inputs are clean and synchronous
// Notes:
`timescale 1ns/10ps
`include "event_log_viewer_ui_cfg.svh"
module event_log_viewer_ui
  import event_log_viewer_ui_pkg::*;
#(
  parameter logic [`TMR_W-1:0] BL_CYCLES    = `TMR_W'(`BL_CYCLES),
  parameter logic [`TMR_W-1:0] PROG_CYCLES  = `TMR_W'(`PROG_CYCLES),
  parameter logic [`TMR_W-1:0] HOLD_CYCLES  = `TMR_W'(`HOLD_CYCLES),
  parameter logic [`TMR_W-1:0] BLINK_CYCLES = `TMR_W'(`BLINK_CYCLES)
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  btn_enter_i,
  input  wire logic                  btn_cancel_i,
  input  wire logic                  btn_up_i,
  input  wire logic                  btn_down_i,
  input  wire logic                  prog_btn_i,
  input  wire logic                  evt_valid_i,
  input  event_log_viewer_ui_pkg::evt_code_t evt_code_i,
  input  wire logic                  link_active_i,
  input  wire logic [`TS_W-1:0]      rtc_time_i,
  input  wire logic [`CODE_W+`TS_W-1:0] nvm_rd_data_i,
  output logic                       nvm_wr_o,
  output logic [`LOG_AW-1:0]         nvm_wr_addr_o,
  output logic [`CODE_W+`TS_W-1:0]   nvm_wr_data_o,
  output logic [`LOG_AW-1:0]         nvm_rd_addr_o,
  output logic                       rtc_load_o,
  output logic [`TS_W-1:0]           rtc_set_o,
  output event_log_viewer_ui_pkg::ui_state_t disp_screen_o,
  output logic [`CODE_W-1:0]         disp_row0_o,
  output logic [`TS_W-1:0]           disp_row1_o,
  output logic                       backlight_o,
  output logic [`LANG_W-1:0]         lang_o,
  output logic                       led_green_o,
  output logic                       led_yellow_o
);
  import event_log_viewer_ui_pkg::*;

  ui_state_t          state_reg;
  prog_item_t         pitem_reg;
  logic [3:0]         btn_prev_reg;
  logic [3:0]         press;
  logic               p_enter, p_cancel, p_up, p_down, any_press;
  logic               bl_exp, prog_exp, hold_exp, hold_prev_reg, hold_fire;
  logic               prog_mode;
  logic [`LOG_AW-1:0] wr_ptr_reg;
  logic [`LOG_AW:0]   rec_count_reg;
  logic [`LOG_AW-1:0] view_off_reg;
  logic [2:0]         fld_reg;
  logic [`FLD_W-1:0]  edit_reg [0:`NUM_FLD-1];
  logic [`LANG_W-1:0] lang_edit_reg;
  logic [`TMR_W-1:0]  blink_cnt_reg;

  // Edge detect: one action per press, however long it is held
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      btn_prev_reg <= 4'h0;
    else
      btn_prev_reg <= {btn_down_i, btn_up_i, btn_cancel_i, btn_enter_i};
  end

  assign press     = {btn_down_i, btn_up_i, btn_cancel_i, btn_enter_i}
                     & ~btn_prev_reg;
  assign p_enter   = press[0];
  assign p_cancel  = press[1];
  assign p_up      = press[2];
  assign p_down    = press[3];
  assign any_press = |press;
  assign prog_mode = (state_reg == ST_PROG) || (state_reg == ST_PMENU) ||
                     (state_reg == ST_SETCLK) || (state_reg == ST_SETLANG);

  idle_timer #(.CYCLES(BL_CYCLES)) u_bl_timer (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .restart_i  (any_press),
    .run_i      (1'b1),
    .expired_o  (bl_exp)
  );

  idle_timer #(.CYCLES(PROG_CYCLES)) u_prog_timer (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .restart_i  (any_press || !prog_mode),
    .run_i      (prog_mode),
    .expired_o  (prog_exp)
  );

  idle_timer #(.CYCLES(HOLD_CYCLES)) u_hold_timer (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .restart_i  (!prog_btn_i),
    .run_i      (1'b1),
    .expired_o  (hold_exp)
  );

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hold_prev_reg <= 1'b0;
    else
      hold_prev_reg <= hold_exp;
  end

  // One entry per hold; keeping the button down does not re-enter
  assign hold_fire = hold_exp && !hold_prev_reg;

  assign backlight_o = !bl_exp;

  // Log write: stamp is the clock value in the arrival cycle
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      nvm_wr_o      <= 1'b0;
      nvm_wr_addr_o <= '0;
      nvm_wr_data_o <= '0;
      wr_ptr_reg    <= '0;
      rec_count_reg <= '0;
    end
    else
    begin
      nvm_wr_o <= evt_valid_i;
      if (evt_valid_i)
      begin
        nvm_wr_addr_o <= wr_ptr_reg;
        nvm_wr_data_o <= {evt_code_i, rtc_time_i};
        wr_ptr_reg    <= wr_ptr_reg + `LOG_AW'(1);
        if (rec_count_reg != (`LOG_AW+1)'(`LOG_DEPTH))
          rec_count_reg <= rec_count_reg + (`LOG_AW+1)'(1);
      end
    end
  end

  // Newest record sits one below the write pointer
  assign nvm_rd_addr_o = wr_ptr_reg - `LOG_AW'(1) - view_off_reg;

  // Menu and mode sequencing
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= ST_NORMAL;
      pitem_reg <= PITEM_DATE;
    end
    else if (prog_mode && prog_exp)
      state_reg <= ST_NORMAL;
    else
    begin
      case (state_reg)
        ST_NORMAL:
          if (hold_fire)
            state_reg <= ST_PROG;
          else if (p_enter)
            state_reg <= ST_MENU;
        ST_MENU:
          if (p_enter)
            state_reg <= ST_BROWSE;
          else if (p_cancel)
            state_reg <= ST_NORMAL;
        ST_BROWSE:
          if (p_cancel)
            state_reg <= ST_MENU;
        ST_PROG:
          if (p_enter)
          begin
            state_reg <= ST_PMENU;
            pitem_reg <= PITEM_DATE;
          end
          else if (p_cancel)
            state_reg <= ST_NORMAL;
        ST_PMENU:
          if (p_down || p_up)
            pitem_reg <= (pitem_reg == PITEM_DATE) ? PITEM_LANG
                                                   : PITEM_DATE;
          else if (p_enter)
            state_reg <= (pitem_reg == PITEM_DATE) ? ST_SETCLK
                                                   : ST_SETLANG;
          else if (p_cancel)
            state_reg <= ST_NORMAL;
        ST_SETCLK:
          if (p_cancel)
            state_reg <= ST_NORMAL;
          else if (p_enter && fld_reg == `FLD_MIN)
            state_reg <= ST_NORMAL;
        ST_SETLANG:
          if (p_cancel || p_enter)
            state_reg <= ST_NORMAL;
        default:
          state_reg <= ST_NORMAL;
      endcase
    end
  end

  // Browse position: zero is the newest record
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      view_off_reg <= '0;
    else if (state_reg == ST_MENU && p_enter)
      view_off_reg <= '0;
    else if (state_reg == ST_BROWSE)
    begin
      if (p_down && ((`LOG_AW+1)'(view_off_reg) + (`LOG_AW+1)'(1)
                     < rec_count_reg))
        view_off_reg <= view_off_reg + `LOG_AW'(1);
      else if (p_up && view_off_reg != '0)
        view_off_reg <= view_off_reg - `LOG_AW'(1);
    end
  end

  function automatic logic [`FLD_W-1:0] fld_lo(input logic [2:0] f);
    fld_lo = (f == `FLD_DAY || f == `FLD_MON) ? `FLD_W'(1) : `FLD_W'(0);
  endfunction

  function automatic logic [`FLD_W-1:0] fld_hi(input logic [2:0] f);
    case (f)
      `FLD_DAY:  fld_hi = `FLD_W'(31);
      `FLD_MON:  fld_hi = `FLD_W'(12);
      `FLD_YEAR: fld_hi = `FLD_W'(99);
      `FLD_HOUR: fld_hi = `FLD_W'(23);
      default:   fld_hi = `FLD_W'(59);
    endcase
  endfunction

  // Clock edit: working copy only; the clock is untouched until the end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fld_reg    <= `FLD_DAY;
      rtc_load_o <= 1'b0;
      rtc_set_o  <= '0;
      for (int i = 0; i < `NUM_FLD; i++)
        edit_reg[i] <= '0;
    end
    else
    begin
      rtc_load_o <= 1'b0;
      if (state_reg == ST_PMENU && p_enter && pitem_reg == PITEM_DATE)
      begin
        fld_reg             <= `FLD_DAY;
        edit_reg[`FLD_DAY]  <= `FLD_W'(rtc_time_i[`TS_DAY_LSB +: `TS_DAY_W]);
        edit_reg[`FLD_MON]  <= `FLD_W'(rtc_time_i[`TS_MON_LSB +: `TS_MON_W]);
        edit_reg[`FLD_YEAR] <= rtc_time_i[`TS_YEAR_LSB +: `TS_YEAR_W];
        edit_reg[`FLD_HOUR] <= `FLD_W'(rtc_time_i[`TS_HOUR_LSB +: `TS_HOUR_W]);
        edit_reg[`FLD_MIN]  <= `FLD_W'(rtc_time_i[`TS_MIN_LSB +: `TS_MIN_W]);
      end
      else if (state_reg == ST_SETCLK && !prog_exp && !p_cancel)
      begin
        // Enter first, so the load always lands in the same cycle as the state change
        if (p_enter && fld_reg != `FLD_MIN)
          fld_reg <= fld_reg + 3'h1;
        else if (p_enter)
        begin
          rtc_load_o <= 1'b1;
          rtc_set_o  <= {edit_reg[`FLD_DAY][`TS_DAY_W-1:0],
                         edit_reg[`FLD_MON][`TS_MON_W-1:0],
                         edit_reg[`FLD_YEAR][`TS_YEAR_W-1:0],
                         edit_reg[`FLD_HOUR][`TS_HOUR_W-1:0],
                         edit_reg[`FLD_MIN][`TS_MIN_W-1:0]};
        end
        else if (p_up)
          edit_reg[fld_reg] <= (edit_reg[fld_reg] >= fld_hi(fld_reg))
                               ? fld_lo(fld_reg)
                               : edit_reg[fld_reg] + `FLD_W'(1);
        else if (p_down)
          edit_reg[fld_reg] <= (edit_reg[fld_reg] <= fld_lo(fld_reg))
                               ? fld_hi(fld_reg)
                               : edit_reg[fld_reg] - `FLD_W'(1);
      end
    end
  end

  // Language: committed only on Enter
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lang_o        <= `LANG_RST;
      lang_edit_reg <= `LANG_RST;
    end
    else if (state_reg == ST_PMENU && p_enter)
      lang_edit_reg <= lang_o;
    else if (state_reg == ST_SETLANG && !prog_exp)
    begin
      if (p_enter && !p_cancel)
        lang_o <= lang_edit_reg;
      else if (p_up && !p_cancel)
        lang_edit_reg <= lang_edit_reg + `LANG_W'(1);
      else if (p_down && !p_cancel)
        lang_edit_reg <= lang_edit_reg - `LANG_W'(1);
    end
  end

  // Display content; the character controller renders 2 x 16
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      disp_screen_o <= ST_NORMAL;
      disp_row0_o   <= '0;
      disp_row1_o   <= '0;
    end
    else
    begin
      disp_screen_o <= state_reg;
      case (state_reg)
        ST_BROWSE:
        begin
          disp_row0_o <= nvm_rd_data_i[`CODE_W+`TS_W-1:`TS_W];
          disp_row1_o <= nvm_rd_data_i[`TS_W-1:0];
        end
        ST_PMENU:
        begin
          disp_row0_o <= `CODE_W'(pitem_reg);
          disp_row1_o <= '0;
        end
        ST_SETCLK:
        begin
          disp_row0_o <= `CODE_W'(fld_reg);
          disp_row1_o <= `TS_W'(edit_reg[fld_reg]);
        end
        ST_SETLANG:
        begin
          disp_row0_o <= `CODE_W'(lang_edit_reg);
          disp_row1_o <= '0;
        end
        default:
        begin
          disp_row0_o <= '0;
          disp_row1_o <= rtc_time_i;
        end
      endcase
    end
  end

  // Status lamps; yellow toggles every half period while the link talks
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      led_green_o   <= 1'b0;
      led_yellow_o  <= 1'b0;
      blink_cnt_reg <= '0;
    end
    else
    begin
      led_green_o <= 1'b1;
      if (!link_active_i)
      begin
        blink_cnt_reg <= '0;
        led_yellow_o  <= 1'b0;
      end
      else if (blink_cnt_reg == BLINK_CYCLES - `TMR_W'(1))
      begin
        blink_cnt_reg <= '0;
        led_yellow_o  <= !led_yellow_o;
      end
      else
        blink_cnt_reg <= blink_cnt_reg + `TMR_W'(1);
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_last_field_enter;
    state_reg == ST_SETCLK && fld_reg == `FLD_MIN && p_enter &&
    !p_cancel && !prog_exp;
  endsequence

  chk_event_stored: assert property (
    evt_valid_i |=> nvm_wr_o && nvm_wr_addr_o == $past(wr_ptr_reg))
    else $error("event not written to log");
  chk_event_stamp: assert property (
    evt_valid_i |=> nvm_wr_data_o[`TS_W-1:0] == $past(rtc_time_i))
    else $error("event timestamp wrong");
  chk_backlight_press: assert property (
    any_press |=> backlight_o [*2])
    else $error("backlight off after press");
  chk_menu_open: assert property (
    state_reg == ST_NORMAL && p_enter && !hold_fire |=> state_reg == ST_MENU)
    else $error("Enter did not open menu");
  chk_browse_newest: assert property (
    state_reg == ST_MENU && p_enter |=>
      state_reg == ST_BROWSE && view_off_reg == '0)
    else $error("browse did not start at newest");
  chk_down_older: assert property (
    state_reg == ST_BROWSE && p_down && view_off_reg == '0 &&
    rec_count_reg > (`LOG_AW+1)'(1) |=> view_off_reg == `LOG_AW'(1))
    else $error("Down did not step older");
  chk_browse_cancel: assert property (
    state_reg == ST_BROWSE && p_cancel |=> state_reg == ST_MENU)
    else $error("Cancel did not leave browsing");
  chk_prog_entry: assert property (
    $rose(state_reg == ST_PROG) |-> $past(hold_fire))
    else $error("programming mode without hold");
  chk_clock_load: assert property (
    s_last_field_enter |=> rtc_load_o && state_reg == ST_NORMAL)
    else $error("clock not loaded after last field");
  chk_clock_cancel: assert property (
    state_reg == ST_SETCLK && p_cancel |=>
      state_reg == ST_NORMAL && !rtc_load_o)
    else $error("Cancel in clock setting misbehaved");
  chk_lang_cancel: assert property (
    state_reg == ST_SETLANG && p_cancel |=>
      lang_o == $past(lang_o) && state_reg == ST_NORMAL)
    else $error("Cancel changed the language");
  chk_prog_timeout: assert property (
    prog_mode && prog_exp |=> state_reg == ST_NORMAL)
    else $error("programming mode did not time out");
  chk_green_lamp: assert property (
    $past(nrst_i) |-> led_green_o)
    else $error("green lamp not steady");
endmodule

/* test/panel_link_model.sv */
// Purpose: panel side of the link, plus log storage for the front end
// Assumes: the bench sends events through send_event
// Notes:   storage reads are combinational, as the front end expects
`timescale 1ns/10ps
`include "event_log_viewer_ui_cfg.svh"
module panel_link_model (
  input  wire logic                         core_clk_i,
  input  wire logic                         nvm_wr_i,
  input  wire logic [`LOG_AW-1:0]           nvm_wr_addr_i,
  input  wire logic [`CODE_W+`TS_W-1:0]     nvm_wr_data_i,
  input  wire logic [`LOG_AW-1:0]           nvm_rd_addr_i,
  output logic      [`CODE_W+`TS_W-1:0]     nvm_rd_data_o,
  output logic                              evt_valid_o,
  output event_log_viewer_ui_pkg::evt_code_t evt_code_o
);
  import event_log_viewer_ui_pkg::*;

  logic [`CODE_W+`TS_W-1:0] mem [`LOG_DEPTH];

  // Unwritten places hold a pattern, so a stray read never looks blank
  initial
  begin
    evt_valid_o = 1'b0;
    evt_code_o  = EVT_POWER_ON;
    for (int i = 0; i < `LOG_DEPTH; i++)
      mem[i] = 35'h5_5555_5555 ^ 35'(i);
  end

  always @(posedge core_clk_i)
  begin
    if (nvm_wr_i)
      mem[nvm_wr_addr_i] <= nvm_wr_data_i;
  end

  assign nvm_rd_data_o = mem[nvm_rd_addr_i];

  // Valid stands one cycle; the code is scrambled once it is no longer valid
  task automatic send_event(input evt_code_t code);
    @(negedge core_clk_i);
    evt_valid_o = 1'b1;
    evt_code_o  = code;
    @(negedge core_clk_i);
    evt_valid_o = 1'b0;
    evt_code_o  = evt_code_t'(~code);
  endtask
endmodule

/* test/event_log_viewer_ui_test.sv */
// Purpose: self-checking bench for the event log viewer front end
// Assumes: short timer parameters stand in for seconds and minutes
// Notes:   inputs change on the falling clock edge
`timescale 1ns/10ps
`include "event_log_viewer_ui_cfg.svh"
`define TB_CHK(nm, exp, got) \
  begin compares++; if ((got) !== (exp)) begin \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); \
  err_count++; end end
module event_log_viewer_ui_test;
  import event_log_viewer_ui_pkg::*;
  localparam logic [`TMR_W-1:0] BL  = 40;
  localparam logic [`TMR_W-1:0] PRG = 200;
  localparam logic [`TMR_W-1:0] HLD = 10;
  localparam logic [`TMR_W-1:0] BLK = 4;
  typedef struct {
    evt_code_t           code;
    logic [`TS_W-1:0]    ts;
    logic [`LOG_AW-1:0]  addr;
  } row_t;

  logic                        core_clk, nrst;
  logic                        b_ent, b_can, b_up, b_dn, prog_btn;
  logic                        evt_valid, link_active;
  evt_code_t                   evt_code;
  logic [`TS_W-1:0]            rtc_time, rtc_set, last_set;
  logic [`CODE_W+`TS_W-1:0]    rd_data, wr_data;
  logic [`LOG_AW-1:0]          wr_addr, rd_addr;
  logic                        nvm_wr, rtc_load, backlight;
  logic                        led_green, led_yellow, yel_prev;
  ui_state_t                   screen;
  logic [`CODE_W-1:0]          row0;
  logic [`TS_W-1:0]            row1;
  logic [`LANG_W-1:0]          lang;
  int                          err_count, compares, loads, toggles;
  row_t                        rows [4];

  event_log_viewer_ui #(.BL_CYCLES(BL), .PROG_CYCLES(PRG),
    .HOLD_CYCLES(HLD), .BLINK_CYCLES(BLK)) u_event_log_viewer_ui (
    .core_clk_i(core_clk), .nrst_i(nrst), .btn_enter_i(b_ent),
    .btn_cancel_i(b_can), .btn_up_i(b_up), .btn_down_i(b_dn),
    .prog_btn_i(prog_btn), .evt_valid_i(evt_valid),
    .evt_code_i(evt_code), .link_active_i(link_active),
    .rtc_time_i(rtc_time), .nvm_rd_data_i(rd_data), .nvm_wr_o(nvm_wr),
    .nvm_wr_addr_o(wr_addr), .nvm_wr_data_o(wr_data),
    .nvm_rd_addr_o(rd_addr), .rtc_load_o(rtc_load), .rtc_set_o(rtc_set),
    .disp_screen_o(screen), .disp_row0_o(row0), .disp_row1_o(row1),
    .backlight_o(backlight), .lang_o(lang), .led_green_o(led_green),
    .led_yellow_o(led_yellow));

  panel_link_model u_panel_link_model (
    .core_clk_i(core_clk), .nvm_wr_i(nvm_wr), .nvm_wr_addr_i(wr_addr),
    .nvm_wr_data_i(wr_data), .nvm_rd_addr_i(rd_addr),
    .nvm_rd_data_o(rd_data), .evt_valid_o(evt_valid),
    .evt_code_o(evt_code));

  function automatic logic [`TS_W-1:0] mk(input int d, m, y, h, n);
    mk = {5'(d), 4'(m), 7'(y), 5'(h), 6'(n)};
  endfunction

  task automatic press(ref logic b);
    @(negedge core_clk);
    b = 1'b1;
    @(negedge core_clk);
    b = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic hold_prog(input int n);
    @(negedge core_clk);
    prog_btn = 1'b1;
    repeat (n) @(negedge core_clk);
    prog_btn = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic chk_rec(input int k);
    `TB_CHK("row0", 8'(rows[k].code), row0)
    `TB_CHK("row1", rows[k].ts, row1)
  endtask

  task automatic wrap_up;
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Load pulses stand one cycle, so sample them mid-cycle
  always @(negedge core_clk)
  begin
    if (rtc_load === 1'b1)
    begin
      loads++;
      last_set = rtc_set;
    end
  end

  // Whole run is about 560 cycles; the limit of 20000 cycles leaves wide margin
  initial
  begin
    #(25 * 20000);
    err_count++;
    wrap_up();
  end

  initial
  begin
    {nrst, b_ent, b_can, b_up, b_dn, prog_btn, link_active} = '0;
    rtc_time = mk(1, 1, 24, 0, 0);
    rows = '{'{EVT_MAINS_LOSS, 27'h0A1B2C3, 8'h00},
             '{EVT_ZONE_FIRE,  27'h1234567, 8'h01},
             '{EVT_ZONE_FAULT, 27'h2C0FFEE, 8'h02},
             '{EVT_SND_FAULT,  27'h7654321, 8'h03}};
    repeat (3) @(negedge core_clk);
    `TB_CHK("screen", ST_NORMAL, screen)
    `TB_CHK("backlight", 1'b1, backlight)
    `TB_CHK("lang", 2'h0, lang)
    `TB_CHK("rd_addr", 8'hFF, rd_addr)
    nrst = 1'b1;
    @(negedge core_clk);
    `TB_CHK("green", 1'b1, led_green)
    foreach (rows[i])
    begin
      rtc_time = rows[i].ts;
      u_panel_link_model.send_event(rows[i].code);
      `TB_CHK("nvm_wr", 1'b1, nvm_wr)
      `TB_CHK("wr_addr", rows[i].addr, wr_addr)
      `TB_CHK("wr_data", {rows[i].code, rows[i].ts}, wr_data)
    end
    press(b_ent);
    `TB_CHK("screen", ST_MENU, screen)
    press(b_ent);
    `TB_CHK("screen", ST_BROWSE, screen)
    chk_rec(3);
    press(b_dn);
    chk_rec(2);
    press(b_dn);
    press(b_dn);
    chk_rec(0);
    press(b_dn);
    chk_rec(0);
    press(b_up);
    chk_rec(1);
    press(b_can);
    `TB_CHK("screen", ST_MENU, screen)
    press(b_can);
    `TB_CHK("screen", ST_NORMAL, screen)
    repeat (BL + 5) @(negedge core_clk);
    `TB_CHK("backlight", 1'b0, backlight)
    press(b_can);
    `TB_CHK("backlight", 1'b1, backlight)
    hold_prog(5);
    `TB_CHK("screen", ST_NORMAL, screen)
    hold_prog(12);
    `TB_CHK("screen", ST_PROG, screen)
    press(b_ent);
    `TB_CHK("item", 8'h00, row0)
    press(b_dn);
    `TB_CHK("item", 8'h01, row0)
    press(b_ent);
    `TB_CHK("screen", ST_SETLANG, screen)
    press(b_up);
    press(b_ent);
    `TB_CHK("lang", 2'h1, lang)
    hold_prog(12);
    press(b_ent);
    press(b_dn);
    press(b_ent);
    press(b_up);
    press(b_can);
    `TB_CHK("lang", 2'h1, lang)
    `TB_CHK("screen", ST_NORMAL, screen)
    rtc_time = mk(5, 3, 20, 10, 30);
    hold_prog(12);
    press(b_ent);
    press(b_ent);
    `TB_CHK("field", 8'(`FLD_DAY), row0)
    `TB_CHK("value", 27'd5, row1)
    press(b_up);
    press(b_ent);
    `TB_CHK("field", 8'(`FLD_MON), row0)
    press(b_dn);
    `TB_CHK("value", 27'd2, row1)
    press(b_ent);
    press(b_ent);
    press(b_ent);
    `TB_CHK("value", 27'd30, row1)
    press(b_ent);
    `TB_CHK("loads", 1, loads)
    `TB_CHK("rtc_set", mk(6, 2, 20, 10, 30), last_set)
    `TB_CHK("screen", ST_NORMAL, screen)
    rtc_time = mk(1, 3, 20, 10, 30);
    hold_prog(12);
    press(b_ent);
    press(b_ent);
    press(b_dn);
    `TB_CHK("value", 27'd31, row1)
    press(b_can);
    `TB_CHK("loads", 1, loads)
    `TB_CHK("screen", ST_NORMAL, screen)
    hold_prog(12);
    press(b_ent);
    press(b_up);
    `TB_CHK("item", 8'h01, row0)
    press(b_ent);
    press(b_up);
    @(negedge core_clk);
    {b_ent, b_can} = 2'b11;
    @(negedge core_clk);
    {b_ent, b_can} = 2'b00;
    repeat (2) @(negedge core_clk);
    `TB_CHK("lang", 2'h1, lang)
    `TB_CHK("screen", ST_NORMAL, screen)
    hold_prog(12);
    repeat (PRG + 5) @(negedge core_clk);
    `TB_CHK("screen", ST_NORMAL, screen)
    link_active = 1'b1;
    toggles = 0;
    yel_prev = led_yellow;
    repeat (40)
    begin
      @(negedge core_clk);
      if (led_yellow !== yel_prev)
        toggles++;
      yel_prev = led_yellow;
    end
    `TB_CHK("blinks", 1'b1, toggles >= 9 && toggles <= 10)
    link_active = 1'b0;
    repeat (3) @(negedge core_clk);
    `TB_CHK("yellow", 1'b0, led_yellow)
    `TB_CHK("green", 1'b1, led_green)
    nrst = 1'b0;
    @(negedge core_clk);
    `TB_CHK("lang", 2'h0, lang)
    `TB_CHK("rd_addr", 8'hFF, rd_addr)
    `TB_CHK("green", 1'b0, led_green)
    nrst = 1'b1;
    @(negedge core_clk);
    `TB_CHK("green", 1'b1, led_green)
    u_panel_link_model.send_event(EVT_POWER_ON);
    `TB_CHK("wr_addr", 8'h00, wr_addr)
    `TB_CHK("nvm_wr", 1'b1, nvm_wr)
    wrap_up();
  end
endmodule
